/* core/mrwe_pkg.sv */
// Shared constants and types of the multi-lane read and wrap engine
package mrwe_pkg;
    // Opcodes
    localparam logic [7:0] OP_DUAL_IO = 8'hbb;
    localparam logic [7:0] OP_QUAD_OUT = 8'h6b;
    localparam logic [7:0] OP_QUAD_IO = 8'heb;
    localparam logic [7:0] OP_WRAP_SET = 8'h77;
    localparam logic [7:0] OP_PAGE_ERASE = 8'h81;
    localparam logic [7:0] OP_WRITE_EN = 8'h06;
    localparam logic [7:0] OP_MODE_RESET = 8'hff;
    // Mode byte, wrap byte and frame lengths
    localparam logic [1:0] CONT_SEL_KEEP = 2'b10;
    localparam logic [2:0] WRAP_RESET = 3'b100;
    localparam logic [5:0] CMD_BITS = 6'h08;
    localparam logic [5:0] ADDR_BITS = 6'h18;
    localparam logic [5:0] MODE_BITS = 6'h08;
    localparam logic [5:0] WRAP_FRAME_BITS = 6'h20;
    localparam logic [5:0] QOUT_DUMMY_CLKS = 6'h08;
    localparam logic [5:0] QIO_DUMMY_CLKS = 6'h04;
    localparam int PAGE_BITS = 8;
    // Timing
    localparam int CLK_MHZ = 10;
    localparam int PAGE_ERASE_US = 8000;
    localparam int PAGE_ERASE_CYCLES = PAGE_ERASE_US * CLK_MHZ;
    // Frame sequencer states
    typedef enum logic [7:0] {
        ST_CMD = 8'h01,
        ST_ADDR = 8'h02,
        ST_MODE = 8'h04,
        ST_DUMMY = 8'h08,
        ST_DATA = 8'h10,
        ST_WRAP = 8'h20,
        ST_ERASE = 8'h40,
        ST_IDLE = 8'h80
    } mrwe_state_t;
    // Refused or finished frames park here so later bits never decode
    localparam mrwe_state_t ST_IGNORE = ST_IDLE;
endpackage : mrwe_pkg

/* core/mrwe_engine.sv */
// Multi-lane read, continuous mode, burst wrap and page erase engine
// What this block does
// - Dual I/O read: opcode on one lane, address and mode byte on two lanes, data.
// - Address taken on rising clock, data driven on falling clock.
// - Read address steps per byte from any start and rolls over to zero.
// - Dual and quad reads are ignored while a write cycle runs.
// - Quad output: opcode and address on one lane, 8 dummy, quad data.
// - Quad I/O: address on four lanes, 2 mode clocks, 4 dummy, data.
// - Dual mode bits 5:4 of 10 skip the opcode on the next frame.
// - Other dual mode bits restore normal opcode decoding next frame.
// - Quad mode bits 5:4 of 10 keep skipping the opcode next frame.
// - Other quad mode bits end continuous mode after chip select toggles.
// - A mode reset command clears continuous mode.
// - Wrap byte bit 4 low selects 8 to 64 byte sections for quad I/O.
// - Page erase: opcode, two page bytes, one dummy byte.
// - Page erase needs the write enable latch, else it is ignored.
// - Chip select high ends a read and stops data drive.
// - Write in progress reads one for the whole self-timed cycle.

module mrwe_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0] count;
    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;

    // Honest flags straight from the occupancy count
    assign in_ready = (count != (PW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];

    // Pointers wrap at the depth, which need not be a power of two
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else if (ce) begin
            if (flush) begin
                wr_ptr <= '0;
                rd_ptr <= '0;
                count <= '0;
            end else begin
                if (push) begin
                    wr_ptr <= (wr_ptr == PW'(DEPTH-1)) ? '0 : wr_ptr + PW'(1);
                end
                if (pop) begin
                    rd_ptr <= (rd_ptr == PW'(DEPTH-1)) ? '0 : rd_ptr + PW'(1);
                end
                count <= count + (PW+1)'(push) - (PW+1)'(pop);
            end
        end
    end

    // Storage
    always_ff @(posedge clk) begin
        if (ce && push && !flush) begin
            mem[wr_ptr] <= in_data;
        end
    end

    a_fifo_bound: assert property (@(posedge clk) disable iff (rst)
        count <= (PW+1)'(DEPTH))
        else $error("fifo count above depth");
endmodule : mrwe_fifo

module mrwe_engine import mrwe_pkg::*; #(
    parameter int AW = 24,
    parameter int FIFO_DEPTH = 8,
    parameter int ERASE_CYCLES = PAGE_ERASE_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic [3:0] io_in,
    output logic [3:0] io_out,
    output logic [3:0] io_oe,
    input wire logic quad_enable_bit,
    input wire logic ext_busy,
    output logic write_in_progress_flag,
    output logic write_enable_latch,
    output logic [2:0] wrap_setting_bits,
    output logic continuous_mode,
    output logic [AW-1:0] rd_addr,
    input wire logic [7:0] mem_data,
    input wire logic mem_valid,
    output logic mem_ready,
    output logic erase_start,
    output logic [AW-PAGE_BITS-1:0] erase_page
);
    localparam int EW = $clog2(ERASE_CYCLES + 1);

    logic [5:0] sync1, sync2;
    logic sclk_d, cs_d;
    mrwe_state_t st;
    logic [7:0] op;
    logic [2:0] lw;
    logic [5:0] cnt;
    logic [31:0] sh;
    logic cont_dual, cont_quad, fetch_on, frame_busy;
    logic [2:0] phase;
    logic [7:0] dsh;
    logic [AW-1:0] er_addr;
    logic erase_busy;
    logic [EW-1:0] ecnt;
    logic fifo_in_ready, fifo_valid;
    logic [7:0] fifo_data;

    // Two-stage synchroniser on every link pin, link clock included
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1 <= 6'h20;
            sync2 <= 6'h20;
            sclk_d <= 1'b0;
            cs_d <= 1'b1;
        end else if (ce) begin
            sync1 <= {cs_n, sclk, io_in};
            sync2 <= sync1;
            sclk_d <= sync2[4];
            cs_d <= sync2[5];
        end
    end

    // Edge and frame events seen on the synchronised pins
    wire cs_s = sync2[5];
    wire [3:0] io_s = sync2[3:0];
    wire rise = ce & sync2[4] & ~sclk_d & ~cs_s;
    wire fall = ce & ~sync2[4] & sclk_d & ~cs_s;
    wire frame_start = ce & cs_d & ~cs_s;
    wire frame_end = ce & ~cs_d & cs_s;
    wire busy = erase_busy | ext_busy;

    // Input shifting per active lane count; dummy clocks count singly
    wire [31:0] next_sh = (lw == 3'd4) ? {sh[27:0], io_s}
                        : (lw == 3'd2) ? {sh[29:0], io_s[1:0]}
                        : {sh[30:0], io_s[0]};
    wire [5:0] next_cnt = cnt + ((st == ST_DUMMY) ? 6'h01 : 6'(lw));
    wire [7:0] dec = next_sh[7:0];
    wire quad_ok = ~busy & quad_enable_bit;
    wire is_dual = (op == OP_DUAL_IO);
    wire wrap_on = (op == OP_QUAD_IO) & ~wrap_setting_bits[2];
    wire [5:0] dummy_end = (op == OP_QUAD_OUT) ? QOUT_DUMMY_CLKS
                                               : QIO_DUMMY_CLKS;
    wire erase_ok = (st == ST_ERASE) & (cnt == ADDR_BITS)
                  & write_enable_latch & ~busy;

    // Fetch address: linear roll-over, or wrap inside an aligned section
    wire [AW-1:0] wmask = AW'(32'h8 << wrap_setting_bits[1:0]) - AW'(1);
    wire [AW-1:0] inc_addr = rd_addr + AW'(1);
    wire [AW-1:0] next_fetch = wrap_on
                             ? ((rd_addr & ~wmask) | (inc_addr & wmask))
                             : inc_addr;
    wire push = mem_valid & mem_ready;
    assign mem_ready = fifo_in_ready & fetch_on;
    assign continuous_mode = cont_dual | cont_quad;
    assign write_in_progress_flag = busy;

    // Byte source on a falling edge: next FIFO word or remaining bits
    wire pop = fall & (st == ST_DATA) & (phase == 3'd0);
    wire [7:0] byte_now = (phase != 3'd0) ? dsh
                        : (fifo_valid ? fifo_data : 8'hff);

    // Frame sequencer, advanced on rising link clock edges
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= ST_IGNORE;
            op <= 8'h00;
            lw <= 3'd1;
            cnt <= 6'h00;
            sh <= 32'h0;
            cont_dual <= 1'b0;
            cont_quad <= 1'b0;
            frame_busy <= 1'b0;
            wrap_setting_bits <= WRAP_RESET;
            er_addr <= '0;
        end else if (frame_start) begin
            cnt <= 6'h00;
            frame_busy <= busy;
            lw <= cont_quad ? 3'd4 : cont_dual ? 3'd2 : 3'd1;
            op <= cont_quad ? OP_QUAD_IO : cont_dual ? OP_DUAL_IO : 8'h00;
            // Opcode skipped while continuous mode holds
            if (continuous_mode && busy) begin
                st <= ST_IGNORE;
                op <= 8'h00;
            end else if (continuous_mode) begin
                st <= ST_ADDR;
            end else begin
                st <= ST_CMD;
            end
        end else if (frame_end) begin
            // A short all-ones frame in continuous mode drops it
            if (st == ST_ADDR && sh[7:0] == OP_MODE_RESET) begin
                cont_dual <= 1'b0;
                cont_quad <= 1'b0;
            end
            st <= ST_IGNORE;
            op <= 8'h00;
        end else if (rise) begin
            sh <= next_sh;
            cnt <= next_cnt;
            case (st)
                ST_CMD: if (next_cnt == CMD_BITS) begin
                    cnt <= 6'h00;
                    op <= dec;
                    st <= ST_IGNORE;
                    if (dec == OP_DUAL_IO && !busy) begin
                        lw <= 3'd2;
                        st <= ST_ADDR;
                    end else if (dec == OP_QUAD_IO && quad_ok) begin
                        lw <= 3'd4;
                        st <= ST_ADDR;
                    end else if (dec == OP_QUAD_OUT && quad_ok) begin
                        st <= ST_ADDR;
                    end else if (dec == OP_WRAP_SET) begin
                        st <= ST_WRAP;
                    end else if (dec == OP_PAGE_ERASE) begin
                        st <= ST_ERASE;
                    end else if (dec == OP_MODE_RESET) begin
                        cont_dual <= 1'b0;
                        cont_quad <= 1'b0;
                    end
                end
                ST_ADDR: if (next_cnt == ADDR_BITS) begin
                    cnt <= 6'h00;
                    st <= (op == OP_QUAD_OUT) ? ST_DUMMY : ST_MODE;
                end
                ST_MODE: if (next_cnt == MODE_BITS) begin
                    cnt <= 6'h00;
                    // Mode bits 5:4 decide the next frame
                    if (is_dual) begin
                        cont_dual <= (dec[5:4] == CONT_SEL_KEEP);
                        st <= ST_DATA;
                    end else begin
                        cont_quad <= (dec[5:4] == CONT_SEL_KEEP);
                        st <= ST_DUMMY;
                    end
                end
                ST_DUMMY: if (next_cnt == dummy_end) begin
                    st <= ST_DATA;
                end
                ST_WRAP: if (next_cnt == WRAP_FRAME_BITS) begin
                    // Disable flag on top, length code below
                    wrap_setting_bits <= {dec[4], dec[6:5]};
                    st <= ST_IGNORE;
                end
                ST_ERASE: if (cnt == ADDR_BITS) begin
                    st <= ST_IGNORE;
                end else if (next_cnt == ADDR_BITS) begin
                    er_addr <= next_sh[AW-1:0];
                end
                default: st <= st;
            endcase
        end
    end

    // Address fetch into the FIFO; source stalls when it is full
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fetch_on <= 1'b0;
            rd_addr <= '0;
        end else if (ce) begin
            if (frame_start || frame_end) begin
                fetch_on <= 1'b0;
            end else if (rise && st == ST_ADDR && next_cnt == ADDR_BITS) begin
                fetch_on <= 1'b1;
                rd_addr <= next_sh[AW-1:0];
            end else if (push) begin
                rd_addr <= next_fetch;
            end
        end
    end

    // Data drive on falling edges; cs high releases the lanes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            io_out <= 4'h0;
            io_oe <= 4'h0;
            phase <= 3'd0;
            dsh <= 8'h00;
        end else if (ce) begin
            if (cs_s || frame_start) begin
                io_oe <= 4'h0;
                phase <= 3'd0;
            end else if (fall && st == ST_DATA) begin
                io_out <= is_dual ? {2'b00, byte_now[7:6]} : byte_now[7:4];
                io_oe <= is_dual ? 4'h3 : 4'hf;
                dsh <= is_dual ? {byte_now[5:0], 2'b00}
                               : {byte_now[3:0], 4'h0};
                phase <= phase + (is_dual ? 3'd2 : 3'd4);
            end
        end
    end

    // Write enable latch and self-timed page erase
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            write_enable_latch <= 1'b0;
            erase_start <= 1'b0;
            erase_busy <= 1'b0;
            ecnt <= '0;
            erase_page <= '0;
        end else if (ce) begin
            erase_start <= frame_end & erase_ok;
            if (erase_start) begin
                erase_busy <= 1'b1;
                ecnt <= EW'(ERASE_CYCLES);
                erase_page <= er_addr[AW-1:PAGE_BITS];
            end else if (erase_busy) begin
                ecnt <= ecnt - EW'(1);
                if (ecnt == EW'(1)) begin
                    erase_busy <= 1'b0;
                    write_enable_latch <= 1'b0;
                end
            end
            if (rise && st == ST_CMD && next_cnt == CMD_BITS
                && dec == OP_WRITE_EN && !busy) begin
                write_enable_latch <= 1'b1;
            end
        end
    end

    mrwe_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .flush(frame_start),
        .in_valid(mem_valid & fetch_on),
        .in_ready(fifo_in_ready),
        .in_data(mem_data),
        .out_valid(fifo_valid),
        .out_ready(pop),
        .out_data(fifo_data)
    );

    a_oe_cs_off: assert property (@(posedge clk) disable iff (rst)
        (ce && cs_s) |=> (io_oe == 4'h0))
        else $error("lanes driven with chip select high");
    a_dual_lanes: assert property (@(posedge clk) disable iff (rst)
        (io_oe != 4'h0 && is_dual) |-> (io_oe == 4'h3))
        else $error("dual read drives wrong lanes");
    a_busy_ignore: assert property (@(posedge clk) disable iff (rst)
        $rose(io_oe != 4'h0) |-> !frame_busy)
        else $error("read served during write cycle");
    a_erase_latch: assert property (@(posedge clk) disable iff (rst)
        $rose(erase_start) |-> $past(write_enable_latch, 1))
        else $error("erase started without latch");
    a_erase_busy: assert property (@(posedge clk) disable iff (rst)
        (erase_start && ce) |=> write_in_progress_flag [*8])
        else $error("busy flag not held during erase");
    a_latch_clear: assert property (@(posedge clk) disable iff (rst)
        $fell(erase_busy) |-> !write_enable_latch)
        else $error("latch kept after erase");
    a_wrap_section: assert property (@(posedge clk) disable iff (rst)
        (ce && push && wrap_on && !frame_start && !frame_end)
        |=> ((rd_addr & ~wmask) == ($past(rd_addr) & ~wmask)))
        else $error("wrapped fetch left its section");
    a_cont_entry: assert property (@(posedge clk) disable iff (rst)
        (frame_start && cont_quad && !busy) |=> (st == ST_ADDR && lw == 3'd4))
        else $error("continuous quad frame not at address");
endmodule : mrwe_engine

/* testbench/mrwe_host_model.sv */
// Host-side serial controller model that drives the engine's link
module mrwe_host_model (
    input wire logic clk,
    output logic sclk,
    output logic cs_n,
    output logic [3:0] io_drv,
    input wire logic [3:0] io_out,
    input wire logic [3:0] io_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] got[$];
    logic [3:0] oe_seen;
    logic [3:0] last_q;
    // Idle link: deselected, clock parked low
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        io_drv = 4'h5;
        oe_seen = 4'h0;
    end
    // One link clock, low 5 and high 3 system clocks; sample late in low
    task automatic pulse(input logic [3:0] d, input bit drv);
        io_drv <= drv ? d : ~io_drv; // Released lanes toggle, never hold
        repeat (4) @(posedge clk);
        @(negedge clk);
        oe_seen = oe_seen | io_oe;
        last_q = io_out;
        @(posedge clk);
        sclk <= 1'b1;
        repeat (3) @(posedge clk);
        sclk <= 1'b0;
    endtask : pulse
    // Lanes always driven while sending, mode clocks too, MSB first
    task automatic send(input int lanes, input logic [31:0] v, input int n);
        for (int k = n - lanes; k >= 0; k -= lanes) begin
            pulse(4'((v >> k) & ((32'h1 << lanes) - 1)), 1'b1);
        end
    endtask : send
    // Collect whole bytes, high bits first, with the lanes released
    task automatic recv(input int lanes, input int nb);
        logic [7:0] b;
        for (int i = 0; i < nb; i++) begin
            for (int k = 0; k < 8 / lanes; k++) begin
                pulse(4'h0, 1'b0);
                b = 8'((b << lanes) | (last_q & ((32'h1 << lanes) - 1)));
            end
            got.push_back(b);
        end
    endtask : recv
    // Frame edges; chip select stays high well over three clocks
    task automatic open_frame();
        @(posedge clk);
        cs_n <= 1'b0;
        oe_seen = 4'h0;
        got.delete();
    endtask : open_frame
    task automatic close_frame();
        @(posedge clk);
        cs_n <= 1'b1;
        io_drv <= ~io_drv;
        repeat (6) @(posedge clk);
    endtask : close_frame
endmodule : mrwe_host_model

/* testbench/mrwe_engine_tb_top.sv */
// Self-checking bench of the multi-lane read and wrap engine
module mrwe_engine_tb_top import mrwe_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic quad_enable_bit = 1'b0;
    logic ext_busy = 1'b0;
    logic ce = 1'b1;
    logic mem_valid = 1'b0;
    logic [7:0] mem_data = 8'h00;
    logic sclk, cs_n, write_in_progress_flag, write_enable_latch;
    logic continuous_mode, mem_ready, erase_start;
    logic [3:0] io_drv, io_out, io_oe;
    logic [2:0] wrap_setting_bits;
    logic [23:0] rd_addr;
    logic [15:0] erase_page;
    wire logic [3:0] lane_level;
    int error_cnt = 0;
    int checks_done = 0;
    int hold = 0;
    int erase_cnt = 0;
    int wrap_sel = 0;
    bit wrap_off = 1'b1;
    int n;
    always #50 clk = ~clk;
    // Wire level: whoever enables a lane drives it
    assign lane_level = (io_oe & io_out) | (~io_oe & io_drv);
    mrwe_host_model u_host (.clk(clk), .sclk(sclk), .cs_n(cs_n),
        .io_drv(io_drv), .io_out(io_out), .io_oe(io_oe));
    mrwe_engine #(.ERASE_CYCLES(400)) u_mrwe_engine (.clk(clk), .rst(rst),
        .ce(ce), .sclk(sclk), .cs_n(cs_n), .io_in(lane_level),
        .io_out(io_out), .io_oe(io_oe), .quad_enable_bit(quad_enable_bit),
        .ext_busy(ext_busy), .write_in_progress_flag(write_in_progress_flag),
        .write_enable_latch(write_enable_latch),
        .wrap_setting_bits(wrap_setting_bits),
        .continuous_mode(continuous_mode), .rd_addr(rd_addr),
        .mem_data(mem_data), .mem_valid(mem_valid), .mem_ready(mem_ready),
        .erase_start(erase_start), .erase_page(erase_page));
    // Array contents are a fold of the address, so bytes within a 256-byte block differ
    function automatic logic [7:0] pat(input logic [23:0] a);
        return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h5a;
    endfunction : pat
    // Byte supply with random stalls; pauses after a push so the
    // data always belongs to the current fetch address
    always @(posedge clk) begin
        if (mem_valid && mem_ready) begin
            mem_valid <= 1'b0;
            hold <= 2;
        end else if (hold != 0) begin
            hold <= hold - 1;
        end else begin
            mem_valid <= mem_ready && ($urandom % 4 != 0);
            mem_data <= pat(rd_addr);
        end
    end
    // Erase launch monitor
    always @(posedge clk) begin
        if (erase_start === 1'b1) begin
            erase_cnt <= erase_cnt + 1;
        end
    end
    task automatic chk(input string nm, input logic [31:0] got,
                       input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic stop_test();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : stop_test
    // One read frame; expected bytes from the address and wrap model
    task automatic rd(input logic [7:0] op, input bit skip,
        input logic [23:0] a, input logic [7:0] m, input int nb, input bit ok);
        logic [23:0] ad;
        int len;
        int w;
        w = op == OP_DUAL_IO ? 2 : 4;
        u_host.open_frame();
        if (!skip) u_host.send(1, {24'h0, op}, 8);
        if (op == OP_QUAD_OUT) begin
            u_host.send(1, a, 24);
            u_host.send(1, 32'h0, 8);
        end else begin
            u_host.send(w, a, 24);
            u_host.send(w, m, 8);
            if (op == OP_QUAD_IO) u_host.send(4, 32'h0, 16);
        end
        u_host.recv(w, nb);
        u_host.close_frame();
        chk("lanes", u_host.oe_seen, ok ? (w == 2 ? 4'h3 : 4'hf) : 4'h0);
        chk("oe_off", io_oe, 4'h0);
        len = (op == OP_QUAD_IO && !wrap_off) ? 8 << wrap_sel : 0;
        for (int i = 0; ok && i < nb; i++) begin
            ad = 24'(len != 0 ? (a & ~(len - 1)) | ((a + i) & (len - 1))
                              : a + i);
            chk("byte", u_host.got[i], pat(ad));
        end
    endtask : rd
    task automatic cmd(input logic [7:0] op, input int nb,
                       input logic [31:0] v);
        u_host.open_frame();
        u_host.send(1, {24'h0, op}, 8);
        if (nb > 0) u_host.send(1, v, nb);
        u_host.close_frame();
        repeat (4) @(posedge clk);
    endtask : cmd
    task automatic set_wrap(input logic [7:0] wb);
        cmd(OP_WRAP_SET, 32, {24'h0, wb});
        wrap_off = wb[4];
        wrap_sel = int'(wb[6:5]);
        chk("wrap", wrap_setting_bits, {wb[4], wb[6:5]});
    endtask : set_wrap
    // Main sequence
    initial begin
        void'($urandom(32'he8d7));
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        chk("wrap_rst", wrap_setting_bits, WRAP_RESET);
        chk("latch_rst", write_enable_latch, 1'b0);
        quad_enable_bit <= 1'b1;
        rd(OP_DUAL_IO, 0, 24'hfffffe, 8'h00, 4, 1);
        chk("cont", continuous_mode, 1'b0);
        rd(OP_DUAL_IO, 0, 24'h000123, 8'h20, 2, 1);
        chk("cont", continuous_mode, 1'b1);
        rd(OP_DUAL_IO, 1, 24'h000456, 8'h00, 3, 1);
        chk("cont", continuous_mode, 1'b0);
        rd(OP_QUAD_OUT, 0, 24'h0abcde, 3, 3, 1);
        quad_enable_bit <= 1'b0;
        rd(OP_QUAD_OUT, 0, 24'h0abcde, 0, 1, 0);
        rd(OP_QUAD_IO, 0, 24'h000777, 8'h00, 1, 0);
        quad_enable_bit <= 1'b1;
        rd(OP_QUAD_IO, 0, 24'h00fffe, 8'h20, 3, 1);
        rd(OP_QUAD_IO, 1, 24'h123456, 8'ha5, 2, 1);
        chk("cont", continuous_mode, 1'b1);
        u_host.open_frame();
        u_host.send(4, 32'hff, 8);
        u_host.close_frame();
        chk("cont", continuous_mode, 1'b0);
        rd(OP_QUAD_IO, 0, 24'h000888, 8'h20, 1, 1);
        rd(OP_QUAD_IO, 1, 24'h000999, 8'h00, 1, 1);
        chk("cont", continuous_mode, 1'b0);
        rd(OP_QUAD_IO, 0, 24'h000abc, 8'h00, 1, 1);
        for (int s = 0; s < 4; s++) begin
            set_wrap({1'b0, 2'(s), 5'h00});
            rd(OP_QUAD_IO, 0, 24'(32'h200 + (8 << s) - 3), 0, 5, 1);
        end
        set_wrap(8'h10);
        rd(OP_QUAD_IO, 0, 24'h0002fd, 8'h00, 5, 1);
        ext_busy <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        chk("busy_flag", write_in_progress_flag, 1'b1);
        rd(OP_DUAL_IO, 0, 24'h000010, 8'h00, 1, 0);
        ext_busy <= 1'b0;
        cmd(OP_PAGE_ERASE, 24, 32'h123400);
        chk("erase", erase_cnt, 0);
        cmd(OP_WRITE_EN, 0, 32'h0);
        chk("latch", write_enable_latch, 1'b1);
        cmd(OP_PAGE_ERASE, 25, 32'h246801);
        chk("erase", erase_cnt, 0);
        cmd(OP_PAGE_ERASE, 24, 32'h123400);
        chk("erase", erase_cnt, 1);
        chk("page", erase_page, 16'h1234);
        chk("busy_flag", write_in_progress_flag, 1'b1);
        // Clock enable low longer than the erase: nothing may move
        ce <= 1'b0;
        repeat (500) @(posedge clk);
        chk("frozen", write_in_progress_flag, 1'b1);
        chk("latch_hold", write_enable_latch, 1'b1);
        ce <= 1'b1;
        rd(OP_QUAD_IO, 0, 24'h000020, 8'h00, 1, 0);
        for (n = 0; n < 1000 && write_in_progress_flag !== 1'b0; n++)
            @(posedge clk);
        if (n == 1000) error_cnt++;
        chk("latch_end", write_enable_latch, 1'b0);
        stop_test();
    end
endmodule : mrwe_engine_tb_top
